// ### core/sms_pkg.sv
/*
  constants for the stepper excitation sequencer: register map, field
  positions, reset values, the current ratio table and position layout.
  assumes a 32-bit apb register bus and a 64-position electrical cycle.
*/
package sms_pkg;
  // position: two quadrant bits over a four-bit sixteenth-of-quarter angle
  localparam int          POS_W            = 6;
  localparam logic [5:0]  POS_RESET        = 6'h08;  // common start point of every mode
  localparam logic [5:0]  TWO_PHASE_OFFSET = 6'h08;  // 2-phase sits between the axes
  localparam logic [5:0]  POS_ONE          = 6'h01;
  localparam logic [4:0]  ANGLE_FULL       = 5'h10;  // sixteen sixteenths

  // apb register map
  localparam logic [7:0]  OFF_CTRL         = 8'h00;
  localparam logic [7:0]  OFF_FULLSCALE    = 8'h04;
  localparam logic [7:0]  OFF_STATUS       = 8'h08;
  localparam int          CTRL_EN_BIT      = 0;
  localparam logic        CTRL_EN_RESET    = 1'b1;
  localparam logic [7:0]  FULLSCALE_RESET  = 8'hFF;
  localparam int          ST_POS_LSB       = 0;   // status [5:0] position
  localparam int          ST_MODE_LSB      = 8;   // status [10:8] mode pins
  localparam int          ST_EN_BIT        = 16;  // status [16] drive enabled

  // current ratios in percent
  localparam logic [7:0]  PCT_FULL         = 8'h64;  // 100
  localparam logic [7:0]  PCT_PSEUDO       = 8'h47;  // 71
  localparam logic [15:0] PCT_DIVISOR      = 16'h0064;
  localparam logic [7:0]  RATIO_TABLE [0:16] = '{
    8'h00, 8'h0B, 8'h14, 8'h1E, 8'h28, 8'h2F, 8'h37, 8'h40, 8'h47,
    8'h4D, 8'h53, 8'h57, 8'h5D, 8'h5F, 8'h61, 8'h64, 8'h64
  };
endpackage

// ### core/sms_sequencer.sv
/*
  excitation sequencer for a unipolar two-phase stepper driver: pin
  synchronisers, step position counter, ratio lookup, full-scale scaling,
  phase drive enables and a small apb register file.
  assumes the seven control pins are asynchronous to CLOCK and much slower than it; the apb port is used unsynchronised.
*/
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
module sms_sequencer (
  input  wire logic        CLOCK,
  input  wire logic        NRST,
  input  wire logic        STEP_CLOCK,
  input  wire logic        EXCITATION_SELECT_LSB,
  input  wire logic        EXCITATION_SELECT_MSB,
  input  wire logic        CLOCK_EDGE_SELECT,
  input  wire logic        ROTATION_DIRECTION,
  input  wire logic        OUTPUT_ENABLE,
  input  wire logic        SYSTEM_RESET_LOW,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic      [7:0]  PHASE_A_RATIO,
  output logic      [7:0]  PHASE_B_RATIO,
  output logic      [7:0]  PHASE_A_CURRENT,
  output logic      [7:0]  PHASE_B_CURRENT,
  output logic             DRIVE_A,
  output logic             DRIVE_A_BAR,
  output logic             DRIVE_B,
  output logic             DRIVE_B_BAR
);
  // pin order in the synchroniser: step, lsb, msb, edge, dir, enable, reset
  logic [6:0] sync1_reg;
  logic [6:0] sync2_reg;
  logic       step_d_reg;
  logic [5:0] pos_reg;
  logic [5:0] pos_next;
  logic       ctrl_en_reg;
  logic [7:0] fullscale_reg;

  // two flops per pin; only the second stage is read by logic
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      sync1_reg  <= 7'h7F;
      sync2_reg  <= 7'h7F;
      step_d_reg <= 1'b1;
    end else begin
      sync1_reg  <= {SYSTEM_RESET_LOW, OUTPUT_ENABLE, ROTATION_DIRECTION, CLOCK_EDGE_SELECT,
                     EXCITATION_SELECT_MSB, EXCITATION_SELECT_LSB, STEP_CLOCK};
      sync2_reg  <= sync1_reg;
      step_d_reg <= sync2_reg[0];
    end
  end

  // synchronised pin levels and mode decode
  wire       step_s    = sync2_reg[0];
  wire [1:0] sel_s     = sync2_reg[2:1];
  wire       edge_s    = sync2_reg[3];
  wire       dir_s     = sync2_reg[4];
  wire       pin_en_s  = sync2_reg[5];
  wire       rst_pin_s = sync2_reg[6];
  wire       rst_all   = !NRST || !rst_pin_s;
  wire       en_eff    = pin_en_s && ctrl_en_reg;
  wire       rise      = step_s && !step_d_reg;
  wire       fall      = !step_s && step_d_reg;
  // disabled core ignores the clock pin, as step events are gated by the enable
  wire       step_evt  = en_eff && (rise || (!edge_s && fall));
  // step of 2^step_log sixteenths: edge high gives 16,8,4,2; low gives 8,4,2,1
  wire [2:0] step_log  = 3'(3'h3 + {2'h0, edge_s} - {1'b0, sel_s});
  wire       two_phase = edge_s && (sel_s == 2'h0);
  wire       full_only = edge_s && !sel_s[1];
  wire       pseudo    = !edge_s && (sel_s == 2'h0);

  // grid stepping: off-grid positions left by a mode change snap to the new grid
  wire [5:0] step_sz = 6'(sms_pkg::POS_ONE << step_log);
  wire [5:0] grid_mk = ~(step_sz - sms_pkg::POS_ONE);
  wire [5:0] offset  = two_phase ? sms_pkg::TWO_PHASE_OFFSET : 6'h00;
  wire [5:0] rel     = pos_reg - offset;
  wire [5:0] fwd_pos = ((rel + step_sz) & grid_mk) + offset;
  wire [5:0] rev_pos = ((rel - sms_pkg::POS_ONE) & grid_mk) + offset;

  // position only moves on a step or a reset, so a mode change alone keeps it
  always_comb begin
    pos_next = pos_reg;
    if (step_evt) begin
      pos_next = dir_s ? rev_pos : fwd_pos;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (rst_all) begin
      pos_reg <= sms_pkg::POS_RESET;
    end else begin
      pos_reg <= pos_next;
    end
  end

  // angle within the quarter: phase b follows the angle, phase a its complement
  wire [3:0] theta   = pos_reg[3:0];
  wire [1:0] quad    = pos_reg[5:4];
  wire [4:0] a_idx   = sms_pkg::ANGLE_FULL - {1'b0, theta};
  wire [7:0] a_tab   = sms_pkg::RATIO_TABLE[a_idx];
  wire [7:0] b_tab   = sms_pkg::RATIO_TABLE[{1'b0, theta}];
  // coarse rising-edge modes run any energized phase at full current
  wire [7:0] a_pct   = (full_only && a_tab != 8'h00) ? sms_pkg::PCT_FULL : a_tab;
  wire [7:0] b_pct   = (full_only && b_tab != 8'h00) ? sms_pkg::PCT_FULL : b_tab;
  wire       a_pos   = (quad[1] == quad[0]);
  wire       b_pos   = !quad[1];
  wire [15:0] a_prod = {8'h00, fullscale_reg} * {8'h00, a_pct};
  wire [15:0] b_prod = {8'h00, fullscale_reg} * {8'h00, b_pct};
  wire [15:0] a_cur  = a_prod / sms_pkg::PCT_DIVISOR;
  wire [15:0] b_cur  = b_prod / sms_pkg::PCT_DIVISOR;

  // outputs registered; disable forces drives off but keeps the position
  always_ff @(posedge CLOCK) begin
    if (rst_all || !en_eff) begin
      PHASE_A_RATIO   <= 8'h00;
      PHASE_B_RATIO   <= 8'h00;
      PHASE_A_CURRENT <= 8'h00;
      PHASE_B_CURRENT <= 8'h00;
      DRIVE_A         <= 1'b0;
      DRIVE_A_BAR     <= 1'b0;
      DRIVE_B         <= 1'b0;
      DRIVE_B_BAR     <= 1'b0;
    end else begin
      PHASE_A_RATIO   <= a_pct;
      PHASE_B_RATIO   <= b_pct;
      PHASE_A_CURRENT <= a_cur[7:0];
      PHASE_B_CURRENT <= b_cur[7:0];
      DRIVE_A         <= (a_pct != 8'h00) && a_pos;
      DRIVE_A_BAR     <= (a_pct != 8'h00) && !a_pos;
      DRIVE_B         <= (b_pct != 8'h00) && b_pos;
      DRIVE_B_BAR     <= (b_pct != 8'h00) && !b_pos;
    end
  end

  // apb decode: one wait-free access, answered in the access cycle
  wire        setup    = PSEL && !PENABLE;
  wire        do_write = PSEL && PENABLE && PREADY && PWRITE;
  wire        hit_ctrl = (PADDR == sms_pkg::OFF_CTRL);
  wire        hit_fs   = (PADDR == sms_pkg::OFF_FULLSCALE);
  wire        hit_st   = (PADDR == sms_pkg::OFF_STATUS);
  wire        mapped   = hit_ctrl || hit_fs || (hit_st && !PWRITE);
  wire [31:0] status_w = (32'(pos_reg) << sms_pkg::ST_POS_LSB)
                       | (32'({edge_s, sel_s}) << sms_pkg::ST_MODE_LSB)
                       | (32'(en_eff) << sms_pkg::ST_EN_BIT);
  wire [31:0] rd_data  = hit_ctrl ? 32'(ctrl_en_reg) << sms_pkg::CTRL_EN_BIT
                       : hit_fs   ? 32'(fullscale_reg)
                       : hit_st   ? status_w
                       : 32'h0000_0000;

  // pready rises for exactly the first access cycle of each transfer
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= setup;
      PRDATA  <= (setup && !PWRITE) ? rd_data : 32'h0000_0000;
      PSLVERR <= setup && !mapped;
    end
  end

  // writes take effect at the access edge only; status and unmapped are ignored
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      ctrl_en_reg   <= sms_pkg::CTRL_EN_RESET;
      fullscale_reg <= sms_pkg::FULLSCALE_RESET;
    end else if (do_write && hit_ctrl) begin
      ctrl_en_reg   <= PWDATA[sms_pkg::CTRL_EN_BIT];
    end else if (do_write && hit_fs) begin
      fullscale_reg <= PWDATA[7:0];
    end
  end

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);

  property p_off_when_disabled;
    !en_eff |=> !DRIVE_A && !DRIVE_A_BAR && !DRIVE_B && !DRIVE_B_BAR && PHASE_A_CURRENT == 8'h00;
  endproperty
  a_off_when_disabled: assert property (p_off_when_disabled)
    else $error("drive active while disabled");

  property p_fwd_fine;
    step_evt && !dir_s && step_log == 3'h0 && !rst_all |=> pos_reg == $past(pos_reg) + 6'h01;
  endproperty
  a_fwd_fine: assert property (p_fwd_fine)
    else $error("forward fine step not plus one");

  property p_rev_fine;
    step_evt && dir_s && step_log == 3'h0 && !rst_all |=> pos_reg == $past(pos_reg) - 6'h01;
  endproperty
  a_rev_fine: assert property (p_rev_fine)
    else $error("reverse fine step not minus one");

  property p_rise_only;
    edge_s && fall && !rst_all |=> $stable(pos_reg);
  endproperty
  a_rise_only: assert property (p_rise_only)
    else $error("falling edge moved position in rising-only mode");

  property p_grid_even;
    step_evt && step_log == 3'h1 && !rst_all |=> pos_reg[0] == 1'b0;
  endproperty
  a_grid_even: assert property (p_grid_even)
    else $error("2w1-2 step left the even grid");

  property p_full_current;
    $past(full_only) && $past(en_eff) && !$past(rst_all) && PHASE_A_RATIO != 8'h00
      |-> PHASE_A_RATIO == 8'h64;
  endproperty
  a_full_current: assert property (p_full_current)
    else $error("rising-edge coarse mode not at full current");

  property p_pseudo_levels;
    $past(pseudo) && step_evt ##1 1'b1 ##1 1'b1 |-> PHASE_B_RATIO inside {8'h00, 8'h47, 8'h64};
  endproperty
  a_pseudo_levels: assert property (p_pseudo_levels)
    else $error("pseudo micro ratio outside 0/71/100");

  property p_scale;
    !$past(rst_all) && $past(en_eff)
      |-> PHASE_B_CURRENT == 8'(({8'h00, $past(fullscale_reg)} * {8'h00, $past(b_pct)}) / 16'h0064);
  endproperty
  a_scale: assert property (p_scale)
    else $error("phase current not scaled from full scale");

  property p_reset_pos;
    rst_all |=> pos_reg == 6'h08;
  endproperty
  a_reset_pos: assert property (p_reset_pos)
    else $error("reset did not restore start position");

  property p_mode_keeps_pos;
    !step_evt && !rst_all |=> $stable(pos_reg);
  endproperty
  a_mode_keeps_pos: assert property (p_mode_keeps_pos)
    else $error("position moved without a step");
endmodule

// ### test/sms_ctl_model.sv
/*
  motion controller model: drives the step clock and the mode, direction,
  enable and reset pins of the sequencer. assumes callers share its clock.
*/
`timescale 1ns/10ps
module sms_ctl_model (
  input  wire logic clk,
  output logic      step_clk,
  output logic      sel_lsb,
  output logic      sel_msb,
  output logic      edge_sel,
  output logic      dir,
  output logic      oe,
  output logic      rst_n
);
  // step pin idles high like its synchroniser preset, so releasing reset makes no edge
  initial begin
    {step_clk, sel_lsb, sel_msb, edge_sel, dir, oe, rst_n} = 7'h4B;
  end
  // each level held six cycles, twice what the synchroniser needs
  task automatic toggle(input int k);
    repeat (k) begin
      @(posedge clk);
      step_clk <= ~step_clk;
      repeat (5) @(posedge clk);
    end
  endtask
  // pins only move while the step clock is quiet
  task automatic set_mode(input logic e, input logic m, input logic l,
                          input logic d, input logic en);
    @(posedge clk);
    {edge_sel, sel_msb, sel_lsb, dir, oe} <= {e, m, l, d, en};
    repeat (4) @(posedge clk);
  endtask
  task automatic pin_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
endmodule

// ### test/stepper_microstep_sequencer_bench.sv
/*
  self-checking bench: apb reads of the status word and direct looks at the
  ratio and current outputs. assumes the controller model drives the pins.
*/
`timescale 1ns/10ps
module stepper_microstep_sequencer_bench;
  logic        clock = 1'b0;
  logic        nrst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata, q;
  logic        pready, pslverr, e;
  logic [7:0]  a_rat, b_rat, a_cur, b_cur;
  logic [3:0]  drv;
  logic        stp, lsb, msb, edg, dir, oe, rst_n;
  logic [5:0]  p;
  int          fs = 255;
  int          err_total = 0;
  int          checks = 0;
  logic [7:0]  pct [0:16] = '{8'h00, 8'h0B, 8'h14, 8'h1E, 8'h28, 8'h2F, 8'h37, 8'h40,
    8'h47, 8'h4D, 8'h53, 8'h57, 8'h5D, 8'h5F, 8'h61, 8'h64, 8'h64};

  always #50 clock = ~clock;

  sms_sequencer sms_sequencer_i (.CLOCK(clock), .NRST(nrst), .STEP_CLOCK(stp),
    .EXCITATION_SELECT_LSB(lsb), .EXCITATION_SELECT_MSB(msb), .CLOCK_EDGE_SELECT(edg),
    .ROTATION_DIRECTION(dir), .OUTPUT_ENABLE(oe), .SYSTEM_RESET_LOW(rst_n),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .PHASE_A_RATIO(a_rat),
    .PHASE_B_RATIO(b_rat), .PHASE_A_CURRENT(a_cur), .PHASE_B_CURRENT(b_cur),
    .DRIVE_A(drv[3]), .DRIVE_A_BAR(drv[2]), .DRIVE_B(drv[1]), .DRIVE_B_BAR(drv[0]));
  sms_ctl_model sms_ctl_model_i (.clk(clock), .step_clk(stp), .sel_lsb(lsb),
    .sel_msb(msb), .edge_sel(edg), .dir(dir), .oe(oe), .rst_n(rst_n));

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checks++;
    if (got !== ex) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // one apb transfer; request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    chk("pready", 1'b1, pready);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // expected ratios follow the angle table; forced modes lift nonzero ratios
  task automatic chk_pos(input logic [5:0] ps, input logic frc);
    logic [7:0] ea, eb;
    logic       ap, bp;
    logic [3:0] ed;
    ea = pct[5'h10 - ps[3:0]];
    eb = pct[ps[3:0]];
    if (frc && ea != 8'h00) ea = 8'h64;
    if (frc && eb != 8'h00) eb = 8'h64;
    apb(1'b0, 8'h08, 32'h0);
    chk("position", ps, q[5:0]);
    chk("ratio_a", ea, a_rat);
    chk("ratio_b", eb, b_rat);
    chk("current_a", ea * fs / 100, a_cur);
    chk("current_b", eb * fs / 100, b_cur);
    // phase a drives its positive side in quadrants 0 and 3, phase b in 0 and 1
    ap = (ps[5:4] == 2'h0) || (ps[5:4] == 2'h3);
    bp = (ps[5:4] < 2'h2);
    ed = {ea != 8'h00 && ap, ea != 8'h00 && !ap, eb != 8'h00 && bp, eb != 8'h00 && !bp};
    chk("drive", ed, drv);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // watchdog: the sequence needs under a thousand cycles, far inside the 40000-cycle limit
  initial begin
    #4000000;
    err_total++;
    conclude();
  end

  initial begin
    nrst    <= 1'b0;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwrite  <= 1'b0;
    paddr   <= 8'h00;
    pwdata  <= 32'h00000000;
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    chk("ctrl", 32'h1, q);
    apb(1'b0, 8'h04, 32'h0);
    chk("fullscale", 32'hFF, q);
    apb(1'b0, 8'h0C, 32'h0);
    chk("unmapped_err", 1'b1, e);
    apb(1'b1, 8'h08, 32'h3F);
    chk("status_wr_err", 1'b1, e);
    chk_pos(6'h08, 1'b1);
    $display("done: registers and reset");
    // every edge and mode pair, each from the common start point
    for (int i = 0; i < 8; i++) begin
      sms_ctl_model_i.set_mode(i[2], i[1], i[0], 1'b0, 1'b1);
      sms_ctl_model_i.pin_reset();
      sms_ctl_model_i.toggle(6);
      p = 6'(8 + (i[2] ? 3 : 6) * ((i[2] ? 16 : 8) >> i[1:0]));
      chk_pos(p, i[2] && !i[1]);
    end
    $display("done: mode table");
    sms_ctl_model_i.set_mode(1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
    sms_ctl_model_i.toggle(8);
    chk_pos(6'h06, 1'b0);
    sms_ctl_model_i.toggle(8);
    chk_pos(6'h3E, 1'b0);
    sms_ctl_model_i.set_mode(1'b0, 1'b1, 1'b1, 1'b1, 1'b1);
    chk_pos(6'h3E, 1'b0);
    sms_ctl_model_i.toggle(2);
    chk_pos(6'h3C, 1'b0);
    $display("done: direction and mode change");
    sms_ctl_model_i.set_mode(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    sms_ctl_model_i.pin_reset();
    sms_ctl_model_i.toggle(1);
    chk_pos(6'h10, 1'b0);
    sms_ctl_model_i.toggle(1);
    chk_pos(6'h18, 1'b0);
    sms_ctl_model_i.set_mode(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    sms_ctl_model_i.toggle(4);
    chk("drive_off", 4'h0, drv);
    sms_ctl_model_i.set_mode(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    apb(1'b1, 8'h00, 32'h0);
    sms_ctl_model_i.toggle(2);
    chk("drive_ctrl_off", 4'h0, drv);
    apb(1'b0, 8'h08, 32'h0);
    chk("enabled", 1'b0, q[16]);
    apb(1'b1, 8'h00, 32'h1);
    fs = 128;
    apb(1'b1, 8'h04, 32'h80);
    repeat (3) @(posedge clock);
    chk_pos(6'h18, 1'b0);
    $display("done: enable and full scale");
    conclude();
  end
endmodule
